// ---- rtl/hsfi_top.sv ----
// module: fault integrator and gate sequencing of a hot-swap controller
// Notes on behaviour
// - while overcurrent is seen the integrator counts up once per counter period.
// - the counter period is 32 us for the short variant and 128 us for the 2 ms variant.
// - an overcurrent shorter than one period still counts as a whole period.
// - reaching the maximum current-limit duration raises an overcurrent fault and drops the gate.
// - with no overcurrent the integrator counts down 128 times slower than up.
// - repeated bursts above a 1/128 duty ratio therefore build up to a fault.
// - an over-temperature indication drops the gate at once.
// - in autoretry, after thermal shutdown the gate stays off for at least the off time.
// - in autoretry, restart waits until the die has cooled 20 degrees below the trip point.
// - in latched mode a thermal fault holds the gate off until a restart action.
// - in latched mode a low-then-high undervoltage input or power cycle clears the fault.
// - a fault cleared by undervoltage toggle still waits out the off time.
// - polarity of supply good, autoretry or latched, and 0.5 or 2 ms limit are build options.
// - in autoretry, an overcurrent fault restarts after the off time.
// - pulling undervoltage low resets a tripped breaker, subject to the off time.
// - the gate turns on only with undervoltage high, overvoltage low, lockout released, sense low; sense high does not turn it off.
`timescale 1ns/1ps
`default_nettype none
module hsfi_top
  import hsfi_pkg::*;
#(
  parameter bit PG_ACTIVE_HIGH = 1'b0,  // supply good output polarity
  parameter bit LATCHED = 1'b0,         // latched fault handling
  parameter bit LONG_LIMIT = 1'b0,      // 2 ms limit variant
  parameter int OFF_TICKS = hsfi_pkg::OFF_TICKS_DEFAULT
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // comparator inputs
  input wire logic overcurrent_in,
  input wire logic overtemp_in,
  input wire logic cooled_in,
  input wire logic undervoltage_sense_input,
  input wire logic overvoltage_sense_input,
  input wire logic supply_lockout_in,
  input wire logic sense_above_limit_in,
  input wire logic drain_low_in,
  // outputs
  output logic gate_enable,
  output logic supply_good_output,
  output logic oc_fault,
  output logic thermal_fault
);
  import hsfi_pkg::*;

  // derived counts for the chosen variant
  localparam int TICK_CYC = LONG_LIMIT ? TICK_LONG_CYC : TICK_SHORT_CYC;
  localparam int LIMIT_TICKS = LONG_LIMIT ? LIMIT_LONG_TICKS : LIMIT_SHORT_TICKS;
  localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYC - 1);
  localparam logic [INT_W-1:0] LIMIT = INT_W'(LIMIT_TICKS);
  localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(OFF_TICKS);

  // synchronised comparator inputs
  logic s_oc;
  logic s_ot;
  logic s_cool;
  logic s_uv;
  logic s_ov;
  logic s_lock;
  logic s_sense;
  logic s_drain;

  hsfi_sync u_sync_oc (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(overcurrent_in), .dout(s_oc));
  hsfi_sync u_sync_ot (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(overtemp_in), .dout(s_ot));
  hsfi_sync u_sync_cool (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(cooled_in), .dout(s_cool));
  hsfi_sync u_sync_uv (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(undervoltage_sense_input), .dout(s_uv));
  hsfi_sync u_sync_ov (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(overvoltage_sense_input), .dout(s_ov));
  hsfi_sync u_sync_lock (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(supply_lockout_in), .dout(s_lock));
  hsfi_sync u_sync_sense (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(sense_above_limit_in), .dout(s_sense));
  hsfi_sync u_sync_drain (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .din(drain_low_in), .dout(s_drain));

  // state
  logic [DIV_W-1:0] div_cnt;
  logic [INT_W-1:0] integ;
  logic [SUB_W-1:0] down_sub;
  logic oc_seen;
  logic [OFF_W-1:0] off_cnt;
  logic uv_was_low;
  hsfi_state_t state;
  logic next_gate;
  logic next_pg;
  logic [DIV_W-1:0] next_div_cnt;
  logic [INT_W-1:0] next_integ;
  logic [SUB_W-1:0] next_down_sub;
  logic next_oc_seen;
  logic [OFF_W-1:0] next_off_cnt;
  logic next_uv_was_low;
  logic next_oc_fault;
  logic next_thermal_fault;
  hsfi_state_t next_state;

  logic tick;
  logic trip_oc;
  logic start_ok;
  logic off_done;

  // combinational helpers
  assign tick = (div_cnt == TICK_LAST);
  assign start_ok = s_uv && !s_ov && !s_lock && !s_sense;
  // strictly greater: the first tick after a fault may land after a partial period
  assign off_done = (off_cnt > OFF_LAST);

  // integrator: up once per period while overcurrent, down 128x slower otherwise
  always_comb
  begin
    next_div_cnt = tick ? DIV_ZERO : div_cnt + 1'b1;
    next_oc_seen = oc_seen || s_oc;
    next_integ = integ;
    next_down_sub = down_sub;
    trip_oc = 1'b0;
    if (tick)
    begin
      next_oc_seen = s_oc;
      if (oc_seen || s_oc) // short pulse counts as full period
      begin
        next_down_sub = SUB_ZERO;
        if (integ + 1'b1 >= LIMIT)
        begin
          trip_oc = 1'b1;
          next_integ = INT_ZERO;
        end
        else
        begin
          next_integ = integ + 1'b1;
        end
      end
      else if (integ != INT_ZERO)
      begin
        if (down_sub == SUB_LAST)
        begin
          next_down_sub = SUB_ZERO;
          next_integ = integ - 1'b1;
        end
        else
        begin
          next_down_sub = down_sub + 1'b1;
        end
      end
      else
      begin
        next_down_sub = SUB_ZERO;
      end
    end
    if (state != HSFI_ON)
    begin
      next_integ = INT_ZERO;
      next_down_sub = SUB_ZERO;
      trip_oc = 1'b0;
    end
  end

  // gate sequencing
  always_comb
  begin
    next_state = state;
    next_off_cnt = off_cnt;
    next_oc_fault = oc_fault;
    next_thermal_fault = thermal_fault;
    next_uv_was_low = uv_was_low || !s_uv;
    if (tick && off_cnt != {OFF_W{1'b1}})
      next_off_cnt = off_cnt + 1'b1;
    unique case (state)
      HSFI_IDLE:
      begin
        if (start_ok && !s_ot)
          next_state = HSFI_ON;
      end
      HSFI_ON:
      begin
        if (s_ot)
        begin
          next_thermal_fault = 1'b1;
          next_off_cnt = OFF_ZERO;
          next_uv_was_low = 1'b0;
          next_state = LATCHED ? HSFI_LATCHED : HSFI_OFFWAIT;
        end
        else if (trip_oc)
        begin
          next_oc_fault = 1'b1;
          next_off_cnt = OFF_ZERO;
          next_uv_was_low = 1'b0;
          next_state = LATCHED ? HSFI_LATCHED : HSFI_OFFWAIT;
        end
        else if (!s_uv || s_ov || s_lock)
        begin
          next_state = HSFI_IDLE;
        end
      end
      HSFI_OFFWAIT:
      begin
        // autoretry waits off time, and for cool-down after thermal trip
        if (off_done && (!thermal_fault || (s_cool && !s_ot)))
        begin
          next_oc_fault = 1'b0;
          next_thermal_fault = 1'b0;
          next_state = HSFI_IDLE;
        end
      end
      HSFI_LATCHED:
      begin
        // cleared by low-then-high undervoltage, still after the off time
        if (uv_was_low && s_uv && off_done && !s_ot)
        begin
          next_oc_fault = 1'b0;
          next_thermal_fault = 1'b0;
          next_state = HSFI_IDLE;
        end
      end
      default:
        next_state = HSFI_IDLE;
    endcase
    next_gate = (next_state == HSFI_ON);
    next_pg = (next_gate && s_drain) ^ !PG_ACTIVE_HIGH;
  end

  // registers; power-on reset clears latched faults
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt <= DIV_ZERO;
      integ <= INT_ZERO;
      down_sub <= SUB_ZERO;
      oc_seen <= 1'b0;
      off_cnt <= OFF_ZERO;
      uv_was_low <= 1'b0;
      state <= HSFI_IDLE;
      gate_enable <= 1'b0;
      supply_good_output <= !PG_ACTIVE_HIGH;
      oc_fault <= 1'b0;
      thermal_fault <= 1'b0;
    end
    else if (clk_en)
    begin
      div_cnt <= next_div_cnt;
      integ <= next_integ;
      down_sub <= next_down_sub;
      oc_seen <= next_oc_seen;
      off_cnt <= next_off_cnt;
      uv_was_low <= next_uv_was_low;
      state <= next_state;
      gate_enable <= next_gate;
      supply_good_output <= next_pg;
      oc_fault <= next_oc_fault;
      thermal_fault <= next_thermal_fault;
    end
  end
endmodule : hsfi_top
`default_nettype wire

// ---- rtl/hsfi_pkg.sv ----
// package: constants and types for the hot-swap fault integrator
package hsfi_pkg;
  // clock rate
  localparam int CLK_HZ = 50_000_000;
  // counter clock periods, in microseconds
  localparam int TICK_SHORT_US = 32;
  localparam int TICK_LONG_US = 128;
  // maximum current-limit durations, in microseconds
  localparam int LIMIT_SHORT_US = 500;
  localparam int LIMIT_LONG_US = 2000;
  // down-count is this many times slower than up-count
  localparam int DOWN_RATIO = 128;
  // cycles per counter period
  localparam int TICK_SHORT_CYC = (CLK_HZ / 1_000_000) * TICK_SHORT_US;
  localparam int TICK_LONG_CYC = (CLK_HZ / 1_000_000) * TICK_LONG_US;
  // integrator thresholds in counter periods (rounded up)
  localparam int LIMIT_SHORT_TICKS = (LIMIT_SHORT_US + TICK_SHORT_US - 1) / TICK_SHORT_US;
  localparam int LIMIT_LONG_TICKS = (LIMIT_LONG_US + TICK_LONG_US - 1) / TICK_LONG_US;
  // widths
  localparam int DIV_W = 13;
  localparam int INT_W = 5;
  localparam int SUB_W = 7;
  localparam int OFF_W = 16;
  // default restart off time in counter periods
  localparam int OFF_TICKS_DEFAULT = 16;
  // reset values, and the last down sub-count
  localparam logic [DIV_W-1:0] DIV_ZERO = 13'h0000;
  localparam logic [INT_W-1:0] INT_ZERO = 5'h00;
  localparam logic [SUB_W-1:0] SUB_ZERO = 7'h00;
  localparam logic [OFF_W-1:0] OFF_ZERO = 16'h0000;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(DOWN_RATIO - 1);

  // gate control states
  typedef enum logic [3:0] {
    HSFI_IDLE    = 4'b0001, // waiting for start conditions
    HSFI_ON      = 4'b0010, // gate enabled
    HSFI_OFFWAIT = 4'b0100, // holding off for the restart off time
    HSFI_LATCHED = 4'b1000  // latched off until undervoltage toggle
  } hsfi_state_t;
endpackage : hsfi_pkg

// ---- rtl/hsfi_sync.sv ----
// module: two-flop synchroniser for comparator inputs
`timescale 1ns/1ps
`default_nettype none
module hsfi_sync (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta;
  logic next_meta;
  logic next_dout;

  // next values
  always_comb
  begin
    next_meta = clk_en ? din : meta;
    next_dout = clk_en ? meta : dout;
  end

  // registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule : hsfi_sync
`default_nettype wire

// ---- verif/hsfi_monitor.sv ----
// checker: port assertions for the fault integrator
`timescale 1ns/1ps
`default_nettype none
module hsfi_monitor
  import hsfi_pkg::*;
#(
  parameter bit PG_ACTIVE_HIGH = 1'b0,
  parameter bit LATCHED = 1'b0,
  parameter bit LONG_LIMIT = 1'b0,
  parameter int OFF_TICKS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // comparators
  input wire logic overtemp_in,
  input wire logic cooled_in,
  input wire logic undervoltage_sense_input,
  input wire logic overvoltage_sense_input,
  // outputs
  input wire logic gate_enable,
  input wire logic supply_good_output,
  input wire logic oc_fault,
  input wire logic thermal_fault
);
  localparam int CYC = LONG_LIMIT ? TICK_LONG_CYC : TICK_SHORT_CYC;
  localparam int LIM = LONG_LIMIT ? LIMIT_LONG_TICKS : LIMIT_SHORT_TICKS;
  logic [31:0] on_t, off_t;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // gate on time, kept a few cycles past its fall, and off time
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      on_t <= '0;
      off_t <= '0;
    end
    else
    begin
      on_t <= gate_enable ? on_t + 1 : (off_t < 4 ? on_t : '0);
      off_t <= gate_enable ? '0 : off_t + 1;
    end
  // causes held long enough to pass the synchroniser
  sequence uv_s; (!undervoltage_sense_input && clk_en) [*4]; endsequence
  sequence ov_s; (overvoltage_sense_input && clk_en) [*4]; endsequence
  sequence hot_s; (overtemp_in && clk_en) [*4]; endsequence
  chk_uv_off: assert property (uv_s |-> !gate_enable) else $error("gate on in uv");
  chk_ov_off: assert property (ov_s |-> !gate_enable) else $error("gate on in ov");
  chk_hot_off: assert property (hot_s |-> !gate_enable) else $error("gate on hot");
  chk_start_ok: assert property ($rose(gate_enable) |->
    $past(undervoltage_sense_input && !overvoltage_sense_input, 2)) else $error("bad start");
  chk_trip_time: assert property ($rose(oc_fault) |->
    !gate_enable && on_t >= (LIM - 1) * CYC) else $error("early trip");
  chk_off_time: assert property (!LATCHED && $fell(oc_fault || thermal_fault) |->
    off_t >= OFF_TICKS * CYC) else $error("short off time");
  chk_cool_first: assert property (!LATCHED && $fell(thermal_fault) |->
    $past(cooled_in, 2)) else $error("not cooled");
  chk_good_gate: assert property (supply_good_output == PG_ACTIVE_HIGH |->
    gate_enable || $past(gate_enable)) else $error("good without gate");
endmodule : hsfi_monitor
bind hsfi_top hsfi_monitor #(.PG_ACTIVE_HIGH(PG_ACTIVE_HIGH), .LATCHED(LATCHED),
  .LONG_LIMIT(LONG_LIMIT), .OFF_TICKS(OFF_TICKS)) u_mon (.*);
`default_nettype wire

// ---- verif/hsfi_load_model.sv ----
// partner: load and transistor seen from the gate output
`timescale 1ns/1ps
`default_nettype none
module hsfi_load_model (
  // clock and controls
  input wire logic clk,
  input wire logic gate_enable,
  input wire logic short_cmd,
  // comparator levels
  output logic overcurrent_in,
  output logic drain_low_in
);
  int ramp = 0;
  // drain falls some cycles after the gate turns on
  always @(posedge clk)
    ramp <= gate_enable ? ramp + 1 : 0;
  assign drain_low_in = ramp >= 20;
  // current flows only through a conducting transistor
  assign overcurrent_in = gate_enable && short_cmd;
endmodule : hsfi_load_model
`default_nettype wire

// ---- verif/tb.sv ----
// testbench: corner and random stimulus for the fault integrator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hsfi_pkg::*;
  localparam int OFFT = 2;
  localparam bit PGH = 1'b1;
  logic clk = 1'b0, arst_n = 1'b0, ot = 1'b0, cool = 1'b1, shrt = 1'b0, en = 1'b1;
  logic [3:0] blk = 4'h1;
  wire logic oc, dl, ge, pg, ocf, thf, gel, thfl;
  int n_mismatch = 0, tests_run = 0, seed = 18710, t, w, k;
  // clock, 20 ns period
  always #10 clk = ~clk;
  // blk bits: undervoltage, overvoltage, lockout, sense high
  hsfi_top #(.PG_ACTIVE_HIGH(PGH), .OFF_TICKS(OFFT)) u_dut (.clk, .arst_n, .clk_en(en),
    .overcurrent_in(oc), .overtemp_in(ot), .cooled_in(cool),
    .undervoltage_sense_input(!blk[0]), .overvoltage_sense_input(blk[1]),
    .supply_lockout_in(blk[2]), .sense_above_limit_in(blk[3]), .drain_low_in(dl),
    .gate_enable(ge), .supply_good_output(pg), .oc_fault(ocf), .thermal_fault(thf));
  // latched variant, thermal path only
  hsfi_top #(.PG_ACTIVE_HIGH(PGH), .LATCHED(1'b1), .OFF_TICKS(OFFT)) u_dut_lat (.clk, .arst_n,
    .clk_en(en), .overcurrent_in(1'b0), .overtemp_in(ot), .cooled_in(cool),
    .undervoltage_sense_input(!blk[0]), .overvoltage_sense_input(blk[1]),
    .supply_lockout_in(blk[2]), .sense_above_limit_in(blk[3]), .drain_low_in(dl),
    .gate_enable(gel), .supply_good_output(), .oc_fault(), .thermal_fault(thfl));
  hsfi_load_model u_load (.clk, .gate_enable(ge), .short_cmd(shrt),
    .overcurrent_in(oc), .drain_low_in(dl));
  // cycles in n counter periods
  function automatic int per(input int n);
    return n * TICK_SHORT_CYC;
  endfunction : per
  // count a compare, report a mismatch
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : chk
  // totals and verdict
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // bounded wait for gate (f=0), overcurrent fault (f=1) or latched gate (f=2) to reach v
  task automatic wait_for(input int f, input logic v, input int n);
    t = 0;
    while ((f == 2 ? gel : (f == 1 ? ocf : ge)) !== v && t < n)
    begin
      @(negedge clk);
      t++;
    end
    n_mismatch += int'(t >= n);
    if (t >= n)
      wrap_up();
  endtask : wait_for
  // main sequence
  initial
  begin
    repeat (3) @(negedge clk);
    chk({ge, ocf, thf, pg}, {3'h0, !PGH});
    arst_n = 1'b1;
    // each blocker alone refuses a start
    for (k = 0; k < 4; k++)
    begin
      blk = 4'h1 << k;
      repeat (8) @(negedge clk);
      chk(ge, 1'b0);
    end
    blk = 4'h0;
    wait_for(0, 1'b1, 8);
    repeat (30) @(negedge clk);
    chk(pg, PGH);
    // clock enable low freezes the synchronisers, so a short undervoltage is not seen
    en = 1'b0;
    blk = 4'h1;
    repeat (10) @(negedge clk);
    chk({ge, gel}, 2'b11);
    blk = 4'h0;
    repeat (2) @(negedge clk);
    en = 1'b1;
    repeat (6) @(negedge clk);
    chk({ge, gel}, 2'b11);
    // held overcurrent trips, then retries after the off time
    shrt = 1'b1;
    wait_for(1, 1'b1, per(17));
    chk(t >= per(15), 1'b1);
    shrt = 1'b0;
    wait_for(0, 1'b1, per(OFFT + 2));
    chk({t >= per(OFFT), ocf}, 2'b10);
    // random short bursts, one per period, each counts whole
    for (k = 0; k < 18 && ocf !== 1'b1; k++)
    begin
      w = 3 + {$random(seed)} % 30;
      shrt = 1'b1;
      repeat (w) @(negedge clk);
      shrt = 1'b0;
      repeat (per(1) - w) @(negedge clk);
    end
    chk({ocf, k >= 7}, 2'b11);
    wait_for(0, 1'b1, per(OFFT + 2));
    // over-temperature holds the gate off until cooled
    cool = 1'b0;
    ot = 1'b1;
    repeat (6) @(negedge clk);
    chk({ge, thf}, 2'b01);
    ot = 1'b0;
    repeat (per(OFFT + 2)) @(negedge clk);
    chk(ge, 1'b0);
    cool = 1'b1;
    wait_for(0, 1'b1, 8);
    chk(thf, 1'b0);
    // latched variant stays off until undervoltage is toggled
    chk({gel, thfl}, 2'b01);
    blk = 4'h1;
    repeat (6) @(negedge clk);
    blk = 4'h0;
    wait_for(2, 1'b1, 8);
    chk(thfl, 1'b0);
    // a toggle right after a fresh fault still waits out the off time
    ot = 1'b1;
    repeat (6) @(negedge clk);
    ot = 1'b0;
    blk = 4'h1;
    repeat (6) @(negedge clk);
    blk = 4'h0;
    repeat (20) @(negedge clk);
    chk({gel, thfl}, 2'b01);
    wait_for(2, 1'b1, per(OFFT + 2));
    chk(t >= per(OFFT) - 32, 1'b1);
    // a power cycle clears a latched fault too
    ot = 1'b1;
    repeat (6) @(negedge clk);
    ot = 1'b0;
    chk({gel, thfl}, 2'b01);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({gel, thfl, ge, thf}, 4'h0);
    arst_n = 1'b1;
    wait_for(2, 1'b1, 8);
    chk(thfl, 1'b0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
